// *** cb_consts.svh ***
`ifndef CB_CONSTS_SVH
`define CB_CONSTS_SVH

`define CB_CFG_ADDR      8'h0A
`define CB_CFG_RESET     8'h00
`define CB_MODE_MSB      7
`define CB_MODE_LSB      6
`define CB_TMO_MSB       5
`define CB_TMO_LSB       4
`define CB_THR_MSB       3
`define CB_THR_LSB       0

`define CB_THR_TOP_MV    3900
`define CB_THR_STEP_MV   100

`define CB_CLK_HZ        50000000
`define CB_SEC_PER_HOUR  3600
`define CB_TMO_BASE_H    1
`define CB_CYC_PER_SEC   (`CB_CLK_HZ * 1)

`endif

// *** cb_pkg.sv ***
package cb_pkg;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_ALWAYS,
    MODE_CHG,
    MODE_CHG_TMO
  } cb_mode_t;

  typedef enum {
    ST_IDLE,
    ST_BAL,
    ST_LOCK
  } cb_state_t;

endpackage

// *** cb_balance_timer.sv ***
`timescale 1ns/1ps
`include "cb_consts.svh"

module cb_balance_timer #(
  parameter int unsigned CYC_PER_SEC  = `CB_CYC_PER_SEC,
  parameter int unsigned SEC_PER_HOUR = `CB_SEC_PER_HOUR
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  input  wire logic       i_run,
  input  wire logic [1:0] i_sel,
  output logic            o_expired
);

  initial begin
    if (CYC_PER_SEC < 1 || SEC_PER_HOUR < 1 ||
        SEC_PER_HOUR * 8 * `CB_TMO_BASE_H > 65535) begin
      $error("cb_balance_timer: unsupported timing parameters");
    end
  end

  // Timeout in seconds: base hours doubled per code step.
  function automatic logic [15:0] tmo_sec(input logic [1:0] sel);
    tmo_sec = 16'((SEC_PER_HOUR * `CB_TMO_BASE_H) << sel);
  endfunction

  logic [31:0] pre_q, pre_d;
  logic [15:0] sec_q, sec_d;
  logic        exp_q, exp_d;

  always_comb begin
    pre_d = pre_q;
    sec_d = sec_q;
    if (!i_run) begin
      pre_d = 32'h0;
      sec_d = 16'h0;
    end else if (sec_q < tmo_sec(i_sel)) begin
      if (pre_q == 32'(CYC_PER_SEC - 1)) begin
        pre_d = 32'h0;
        sec_d = sec_q + 16'h1;
      end else begin
        pre_d = pre_q + 32'h1;
      end
    end
    exp_d = i_run && (sec_d >= tmo_sec(i_sel));
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_q <= 32'h0;
      sec_q <= 16'h0;
      exp_q <= 1'b0;
    end else if (i_ce) begin
      pre_q <= pre_d;
      sec_q <= sec_d;
      exp_q <= exp_d;
    end
  end

  assign o_expired = exp_q;

  tmo_decode_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(exp_q) |-> sec_q >= tmo_sec(i_sel))
    else $error("timer expired before the selected timeout");

endmodule // cb_balance_timer

// *** cell_balance_controller.sv ***
`timescale 1ns/1ps
`include "cb_consts.svh"

module cell_balance_controller
  import cb_pkg::*;
#(
  parameter int unsigned NUM_CELLS    = 8,
  parameter int unsigned VOLT_W       = 13,
  parameter int unsigned CYC_PER_SEC  = `CB_CYC_PER_SEC,
  parameter int unsigned SEC_PER_HOUR = `CB_SEC_PER_HOUR
) (
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_ce,
  input  wire logic [NUM_CELLS*VOLT_W-1:0] i_cell_mv,
  input  wire logic                        i_chg_det,
  input  wire logic                        i_reg_wr,
  input  wire logic [7:0]                  i_reg_addr,
  input  wire logic [7:0]                  i_reg_wdata,
  output logic      [7:0]                  o_reg_rdata,
  output logic      [NUM_CELLS-1:0]        o_bleed,
  output logic                             o_balancing
);

  initial begin
    if (NUM_CELLS < 1 || NUM_CELLS > 32 || VOLT_W < 12 || VOLT_W > 16) begin
      $error("cell_balance_controller: unsupported parameters");
    end
  end

  // Threshold in millivolts for a 4-bit select code.
  function automatic logic [VOLT_W-1:0] thr_mv(input logic [3:0] sel);
    thr_mv = VOLT_W'(`CB_THR_TOP_MV - `CB_THR_STEP_MV * int'(sel));
  endfunction

  // Configuration register.
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] rdata_q, rdata_d;
  logic       cfg_hit;

  assign cfg_hit = (i_reg_addr == `CB_CFG_ADDR);

  always_comb begin
    cfg_d   = cfg_q;
    rdata_d = cfg_hit ? cfg_q : 8'h00;
    if (i_reg_wr && cfg_hit) begin
      cfg_d = i_reg_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_q   <= `CB_CFG_RESET;
      rdata_q <= 8'h00;
    end else if (i_ce) begin
      cfg_q   <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_reg_rdata = rdata_q;

  cb_mode_t    mode;
  logic [1:0]  tmo_sel;
  logic [3:0]  thr_sel;

  assign mode    = cb_mode_t'(cfg_q[`CB_MODE_MSB:`CB_MODE_LSB]);
  assign tmo_sel = cfg_q[`CB_TMO_MSB:`CB_TMO_LSB];
  assign thr_sel = cfg_q[`CB_THR_MSB:`CB_THR_LSB];

  // Per-cell comparison; any cell at threshold means the highest does.
  logic [NUM_CELLS-1:0] above;
  logic                 any_above;

  generate
    for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cmp
      assign above[c] = i_cell_mv[c*VOLT_W +: VOLT_W] >= thr_mv(thr_sel);
    end
  endgenerate

  assign any_above = |above;

  // Balance sequencer.
  cb_state_t st_q, st_d;
  logic      tmr_exp;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        // Leaving idle requires real bleeding so the timer starts with it.
        case (mode)
          MODE_ALWAYS:  if (any_above) st_d = ST_BAL;
          MODE_CHG,
          MODE_CHG_TMO: if (any_above && i_chg_det) st_d = ST_BAL;
          default:      st_d = ST_IDLE;
        endcase
      end
      ST_BAL: begin
        case (mode)
          MODE_ALWAYS: begin
            if (tmr_exp) st_d = ST_LOCK;
            else if (!any_above) st_d = ST_IDLE;
          end
          MODE_CHG: begin
            if (!i_chg_det || !any_above) st_d = ST_IDLE;
          end
          MODE_CHG_TMO: begin
            if (!i_chg_det) st_d = ST_IDLE;
            else if (tmr_exp) st_d = ST_LOCK;
            else if (!any_above) st_d = ST_IDLE;
          end
          default: st_d = ST_IDLE;
        endcase
      end
      ST_LOCK: begin
        case (mode)
          MODE_ALWAYS:  if (!any_above) st_d = ST_IDLE;
          MODE_CHG_TMO: if (!i_chg_det) st_d = ST_IDLE;
          default:      st_d = ST_IDLE;
        endcase
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Bleed follows the cells above threshold only while balancing.
  logic [NUM_CELLS-1:0] bleed_q, bleed_d;
  logic                 bal_q, bal_d;

  always_comb begin
    bal_d   = (st_d == ST_BAL);
    bleed_d = bal_d ? above : '0;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q    <= ST_IDLE;
      bleed_q <= '0;
      bal_q   <= 1'b0;
    end else if (i_ce) begin
      st_q    <= st_d;
      bleed_q <= bleed_d;
      bal_q   <= bal_d;
    end
  end

  assign o_bleed     = bleed_q;
  assign o_balancing = bal_q;

  // The timer runs only while bleeding; mode 10 ignores its expiry.
  cb_balance_timer #(
    .CYC_PER_SEC  (CYC_PER_SEC),
    .SEC_PER_HOUR (SEC_PER_HOUR)
  ) u_timer (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_run     (st_q == ST_BAL),
    .i_sel     (tmo_sel),
    .o_expired (tmr_exp)
  );

  off_no_bleed_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && mode == MODE_OFF) |=> (o_bleed == '0 && !o_balancing))
    else $error("bleeding while balancing disabled");

  start_always_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && st_q == ST_IDLE && mode == MODE_ALWAYS && any_above)
      |=> (st_q == ST_BAL && o_balancing))
    else $error("mode 01 did not start at threshold");

  lock_restart_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && st_q == ST_LOCK && mode == MODE_ALWAYS && any_above)
      |=> st_q == ST_LOCK)
    else $error("mode 01 restarted without all cells dropping");

  chg_removed_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && st_q == ST_BAL && mode inside {MODE_CHG, MODE_CHG_TMO}
      && !i_chg_det) |=> (st_q == ST_IDLE && o_bleed == '0))
    else $error("balancing continued after charger removal");

  tmo_stop_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && st_q == ST_BAL && mode == MODE_CHG_TMO && i_chg_det && tmr_exp)
      |=> (st_q == ST_LOCK && !o_balancing))
    else $error("mode 11 did not stop at timeout");

  lock_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st_q == ST_LOCK && mode == MODE_CHG_TMO && i_chg_det) |=> st_q == ST_LOCK)
    else $error("mode 11 resumed without charger reconnect");

  timer_idle_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && st_q != ST_BAL) |=> !tmr_exp)
    else $error("timer ran while not bleeding");

  bleed_match_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && st_d == ST_BAL) |=> o_bleed == $past(above))
    else $error("bleed does not follow cells above threshold");

  start_cause_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st_q == ST_IDLE && !any_above) |=> !o_balancing)
    else $error("balancing started with no cell at threshold");

  always_bal_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    mode == MODE_ALWAYS && st_q == ST_IDLE ##1 st_q == ST_BAL);

  tmo_lock_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    st_q == ST_BAL ##1 st_q == ST_LOCK);

  reconnect_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    mode == MODE_CHG_TMO && st_q == ST_LOCK ##1 st_q == ST_IDLE
      ##[1:20] st_q == ST_BAL);

endmodule // cell_balance_controller

// *** cb_cell_model.sv ***
`timescale 1ns/1ps

module cb_cell_model #(
  parameter int unsigned NUM_CELLS = 8,
  parameter int unsigned VOLT_W    = 13
) (
  output logic [NUM_CELLS*VOLT_W-1:0] o_cell_mv,
  output logic                        o_chg_det
);
  // One cell may be lifted; an index of -1 leaves all at the base level.
  task automatic set_cells(input int base, input int idx, input int hi);
    for (int c = 0; c < NUM_CELLS; c++) begin
      o_cell_mv[c*VOLT_W +: VOLT_W] = VOLT_W'((c == idx) ? hi : base);
    end
  endtask

  task automatic set_chg(input logic det);
    o_chg_det = det;
  endtask
endmodule // cb_cell_model

// *** tb_cell_balance_controller.sv ***
`timescale 1ns/1ps

module tb_cell_balance_controller;
  localparam int HOUR = 8;
  localparam int LOW  = 2000;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        wr = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        ce = 1'b1;
  logic [7:0]  rdata;
  logic [7:0]  bleed;
  logic        bal;
  logic [103:0] cell_mv;
  logic        chg;
  logic [8:0]  exp_q[$];
  logic [7:0]  reg_q[$];
  event        ev_bal;
  event        ev_reg;
  int          bad_count = 0;
  int          n_checks = 0;
  int          thr;
  int          idx;

  always #10 i_mclk = ~i_mclk;

  cb_cell_model i_cb_cell_model (.o_cell_mv(cell_mv), .o_chg_det(chg));

  cell_balance_controller #(.CYC_PER_SEC(4), .SEC_PER_HOUR(2))
    i_cell_balance_controller (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(ce), .i_cell_mv(cell_mv),
    .i_chg_det(chg), .i_reg_wr(wr), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_bleed(bleed),
    .o_balancing(bal));

  task automatic end_of_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmp_bal(input logic [8:0] e, input logic [8:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %0t bleed/bal %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_reg(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %0t rdata %h expected %h", $time, g, e);
    end
  endtask

  // The monitor compares the oldest note whenever a result is sampled.
  always @(ev_bal) cmp_bal(exp_q.pop_front(), {bleed, bal});
  always @(ev_reg) cmp_reg(reg_q.pop_front(), rdata);

  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic exp_bal(input logic [7:0] b, input logic on);
    exp_q.push_back({b, on});
    ->ev_bal;
  endtask

  task automatic wr_cfg(input logic [7:0] v);
    addr = 8'h0A;
    wdata = v;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    step(1);
    reg_q.push_back(e);
    ->ev_reg;
  endtask

  task automatic cells(input int i, input int mv);
    i_cb_cell_model.set_cells(LOW, i, mv);
  endtask

  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end

  initial begin
    void'($urandom(93));
    cells(-1, LOW);
    i_cb_cell_model.set_chg(1'b1);
    step(12);
    exp_bal(8'h00, 1'b0);
    i_rst_n = 1'b1;
    rd(8'h0A, 8'h00);
    rd(8'h0B, 8'h00);
    // A write to an unmapped address must leave the configuration alone.
    addr = 8'h0B;
    wdata = 8'hC0;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    rd(8'h0A, 8'h00);
    wr_cfg(8'h3F);
    cells(3, 3900);
    step(2);
    exp_bal(8'h00, 1'b0);
    wr_cfg(8'h9F);
    rd(8'h0A, 8'h9F);
    rd(8'h09, 8'h00);
    for (int k = 0; k < 5; k++) begin
      thr = (k == 0) ? 0 : (k == 1) ? 15 : $urandom_range(15, 0);
      idx = $urandom_range(7, 0);
      wr_cfg(8'h80 | 8'(thr));
      cells(idx, 3899 - 100 * thr);
      step(2);
      exp_bal(8'h00, 1'b0);
      cells(idx, 3900 - 100 * thr);
      step(2);
      exp_bal(8'h01 << idx, 1'b1);
      cells(-1, LOW);
      step(2);
      exp_bal(8'h00, 1'b0);
    end
    cells(5, 3900);
    step(HOUR * 2 + 10);
    exp_bal(8'h20, 1'b1);
    i_cb_cell_model.set_chg(1'b0);
    step(2);
    exp_bal(8'h00, 1'b0);
    for (int s = 0; s < 4; s++) begin
      wr_cfg(8'h40 | 8'(s << 4));
      cells(-1, LOW);
      step(2);
      cells(s, 3900);
      step(HOUR * (1 << s) + 1);
      exp_bal(8'h01 << s, 1'b1);
      step(1);
      exp_bal(8'h00, 1'b0);
    end
    step(5);
    exp_bal(8'h00, 1'b0);
    cells(-1, LOW);
    step(2);
    cells(6, 3950);
    step(2);
    exp_bal(8'h40, 1'b1);
    wr_cfg(8'hC0);
    cells(-1, LOW);
    i_cb_cell_model.set_chg(1'b1);
    step(20);
    cells(2, 3900);
    step(HOUR + 1);
    exp_bal(8'h04, 1'b1);
    step(1);
    exp_bal(8'h00, 1'b0);
    cells(-1, LOW);
    step(2);
    cells(2, 3900);
    step(2);
    exp_bal(8'h00, 1'b0);
    i_cb_cell_model.set_chg(1'b0);
    step(2);
    i_cb_cell_model.set_chg(1'b1);
    step(2);
    exp_bal(8'h04, 1'b1);
    i_cb_cell_model.set_chg(1'b0);
    step(2);
    exp_bal(8'h00, 1'b0);
    // A low enable must hold off the start that the charger asks for.
    ce = 1'b0;
    i_cb_cell_model.set_chg(1'b1);
    step(3);
    exp_bal(8'h00, 1'b0);
    ce = 1'b1;
    step(1);
    exp_bal(8'h04, 1'b1);
    i_rst_n = 1'b0;
    step(2);
    exp_bal(8'h00, 1'b0);
    i_rst_n = 1'b1;
    rd(8'h0A, 8'h00);
    exp_bal(8'h00, 1'b0);
    step(1);
    end_of_test();
  end
endmodule // tb_cell_balance_controller
